// File: verilog/wwt_defines.svh
// Constants of the windowed watchdog: addresses, key values, option fields and timing.
`ifndef WWT_DEFINES_SVH
`define WWT_DEFINES_SVH

`define WWT_KEY_ADDR 16'hff99
`define WWT_KEY_VALUE 8'hac
`define WWT_KEY_RST_OFF 8'h1a
`define WWT_KEY_RST_ON 8'h9a
`define WWT_OPT_ADDR 16'h0080
`define WWT_OPT_WIN_HI 6
`define WWT_OPT_WIN_LO 5
`define WWT_OPT_ENABLE 4
`define WWT_OPT_OVF_HI 3
`define WWT_OPT_OVF_LO 1
`define WWT_OPT_LOCK 0
`define WWT_EXEMPT_BASE 16'hfb00
`define WWT_SFR_BASE 16'hff00
`define WWT_ROM_UNIT_LOG2 10
`define WWT_CNT_W 17
`define WWT_CNT_MAX 17'h1_ffff
`define WWT_OVF_MAX_CODE 3'h7
`define WWT_SYS_CLK_HZ 10000000
`define WWT_SLOW_CLK_HZ 250000
`define WWT_SLOW_DIV (`WWT_SYS_CLK_HZ / `WWT_SLOW_CLK_HZ)

`endif

// File: verilog/wwt_pkg.sv
// Types shared by the windowed watchdog modules.
package wwt_pkg;

  typedef enum logic [2:0] {
    wwt_cause_none,
    wwt_cause_overflow,
    wwt_cause_bad_key,
    wwt_cause_bit_op,
    wwt_cause_closed_write,
    wwt_cause_bad_fetch,
    wwt_cause_bad_access
  } wwt_cause_t;

endpackage : wwt_pkg

// File: verilog/wwt_tick_if.sv
// Link between the watchdog core and its low-speed tick divider.
`timescale 1ns/1ps
interface wwt_tick_if;
  logic run;
  logic restart;
  logic tick;

  modport gen
  (
    input run,
    input restart,
    output tick
  );

  modport use_tick
  (
    output run,
    output restart,
    input tick
  );
endinterface : wwt_tick_if

// File: verilog/wwt_slow_tick.sv
// Divider that models the low-speed oscillator as a one-cycle enable.
`timescale 1ns/1ps
`include "wwt_defines.svh"
module wwt_slow_tick #(
  parameter int DIV = `WWT_SLOW_DIV
)
(
  input wire logic sys_clk,
  input wire logic srst,
  wwt_tick_if.gen tick_bus
);

  logic [15:0] phase;

  // The phase restarts with each counter clear so a clear costs at most one tick.
  always_ff @(posedge sys_clk)
  begin
    if (srst || tick_bus.restart)
    begin
      phase <= 16'h0000;
      tick_bus.tick <= 1'b0;
    end
    else if (tick_bus.run)
    begin
      if (phase == 16'(DIV - 1))
      begin
        phase <= 16'h0000;
        tick_bus.tick <= 1'b1;
      end
      else
      begin
        phase <= phase + 16'h0001;
        tick_bus.tick <= 1'b0;
      end
    end
    else
    begin
      tick_bus.tick <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_tick_needs_run;
    tick_bus.tick |-> $past(tick_bus.run);
  endproperty
  a_tick_needs_run: assert property (p_tick_needs_run)
    else $error("Tick produced while the oscillator was stopped.");

  property p_tick_spacing;
    tick_bus.tick |=> !tick_bus.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("Two ticks in adjacent cycles.");

endmodule : wwt_slow_tick

// File: verilog/wwt_watchdog.sv
// Windowed watchdog core with restart key register and illegal access detection.
//
// Overview of operation
// - Key write ACH in a permitted time clears the counter and restarts counting.
// - Reset loads the key register with 1AH if disabled, 9AH if enabled.
// - Any non-ACH key write resets; deferred until the stopped clock resumes.
// - A bit-level key write resets; deferred until the stopped clock resumes.
// - Reading the key register returns its reset value, never the key.
// - Option byte: window bits 6-5, enable bit 4, overflow bits 3-1.
// - Enable 1 starts counting and access checks; 0 keeps both off.
// - Later key writes must fall in the open window, else reset.
// - The first key write after reset clears the counter regardless of window.
// - Reaching the overflow time without a valid key write raises reset.
// - An instruction fetch outside the configured memory raises reset.
// - A data access outside configured memory resets; FB00H-FFFFH exempt.
// - A clear may shift the overflow time by at most one slow period.
// - A key write in the last count before overflow still clears.
// - Halt and stop pause the count with lock 0, not with lock 1.
// - With lock 0 counting resumes from the held value after halt or stop.
// - With lock 0 the oscillator stop bit pauses and keeps the count.
// - Overflow period is 2 to the power (10 plus code) slow cycles.
// - Counting continues during flash self-programming.
// - Window codes 00 to 11 open 25, 50, 75 and 100 percent.
// - Each watchdog reset sets the watchdog reset flag.
`timescale 1ns/1ps
`include "wwt_defines.svh"
module wwt_watchdog #(
  parameter int SLOW_DIV = `WWT_SLOW_DIV
)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] opt_byte,
  input wire logic [7:0] memory_size_reg,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic cpu_fetch,
  input wire logic cpu_bit_op,
  input wire logic [7:0] cpu_wdata,
  input wire logic halt_mode,
  input wire logic stop_mode,
  input wire logic lowspeed_osc_stop,
  input wire logic flash_self_prog,
  input wire logic flag_clear,
  output logic [7:0] cpu_rdata,
  output logic wdt_reset_req,
  output logic watchdog_reset_flag,
  output wwt_pkg::wwt_cause_t reset_cause
);

  logic [7:0] watchdog_option_config;
  logic [7:0] restart_key_reg;
  logic [`WWT_CNT_W-1:0] count;
  logic first_done;
  logic pending_err;
  logic count_enable_opt;
  logic lowspeed_osc_lock;
  logic [2:0] overflow_select;
  logic window_select_hi;
  logic window_select_lo;
  logic clk_stopped;
  logic [`WWT_CNT_W-1:0] last_count;
  logic [`WWT_CNT_W-1:0] close_limit;
  logic key_hit;
  logic key_bad;
  logic key_closed;
  logic key_good;
  logic fetch_bad;
  logic access_bad;
  logic overflow;
  logic err_now;
  logic fire;
  wwt_pkg::wwt_cause_t next_cause;

  wwt_tick_if tick_bus ();

  wwt_slow_tick #(
    .DIV(SLOW_DIV)
  ) u_slow_tick (
    .sys_clk(sys_clk),
    .srst(srst),
    .tick_bus(tick_bus)
  );

  // Last count value before overflow for an overflow code.
  function automatic logic [`WWT_CNT_W-1:0] ovf_last(input logic [2:0] code);
    ovf_last = `WWT_CNT_MAX >> (`WWT_OVF_MAX_CODE - code);
  endfunction : ovf_last

  // Count at which the window opens; the closed part comes first.
  function automatic logic [`WWT_CNT_W-1:0] win_close(
    input logic [2:0] code,
    input logic [1:0] win
  );
    logic [`WWT_CNT_W:0] quarter;
    quarter = ({1'b0, ovf_last(code)} + 18'h0_0001) >> 2;
    win_close = `WWT_CNT_W'(quarter * (18'h0_0003 - {16'h0000, win}));
  endfunction : win_close

  // Address map check: data may also reach the exempt top area, fetches stop below SFRs.
  function automatic logic in_map(
    input logic [15:0] addr,
    input logic [7:0] mem_size,
    input logic is_fetch
  );
    logic [16:0] rom_top;
    logic in_rom;
    // The size sum is five bits wide so the largest setting does not wrap to zero.
    rom_top = {2'h0, {1'b0, mem_size[3:0]} + 5'h01, 10'h000};
    in_rom = {1'b0, addr} < rom_top;
    if (is_fetch)
    begin
      in_map = in_rom || (addr >= `WWT_EXEMPT_BASE && addr < `WWT_SFR_BASE);
    end
    else
    begin
      in_map = in_rom || addr >= `WWT_EXEMPT_BASE;
    end
  endfunction : in_map

  // The option byte is caught while reset is held.
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      watchdog_option_config <= opt_byte;
    end
  end

  always_comb
  begin
    window_select_hi = watchdog_option_config[`WWT_OPT_WIN_HI];
    window_select_lo = watchdog_option_config[`WWT_OPT_WIN_LO];
    count_enable_opt = watchdog_option_config[`WWT_OPT_ENABLE];
    overflow_select = watchdog_option_config[`WWT_OPT_OVF_HI:`WWT_OPT_OVF_LO];
    lowspeed_osc_lock = watchdog_option_config[`WWT_OPT_LOCK];
  end

  // Flash self-programming is deliberately not a pause condition.
  assign clk_stopped = !lowspeed_osc_lock
    && (halt_mode || stop_mode || lowspeed_osc_stop);
  assign last_count = ovf_last(overflow_select);
  assign close_limit = win_close(overflow_select,
    {window_select_hi, window_select_lo});

  assign tick_bus.run = !clk_stopped;
  assign tick_bus.restart = key_good;

  always_comb
  begin
    key_hit = cpu_wr && cpu_addr == `WWT_KEY_ADDR;
    key_bad = key_hit && (cpu_bit_op || cpu_wdata != `WWT_KEY_VALUE);
    key_closed = key_hit && !key_bad && count_enable_opt && first_done
      && count < close_limit;
    key_good = key_hit && !key_bad && !key_closed;
    fetch_bad = count_enable_opt && cpu_fetch
      && !in_map(cpu_addr, memory_size_reg, 1'b1);
    access_bad = count_enable_opt && (cpu_rd || cpu_wr)
      && !in_map(cpu_addr, memory_size_reg, 1'b0);
    overflow = tick_bus.tick && !clk_stopped && count_enable_opt
      && count == last_count && !key_good;
    err_now = key_bad || key_closed || fetch_bad || access_bad;
  end

  // Key errors on a stopped clock wait for the clock to run again.
  assign fire = overflow || (!clk_stopped && (err_now || pending_err));

  always_comb
  begin
    next_cause = reset_cause;
    if (overflow)
    begin
      next_cause = wwt_pkg::wwt_cause_overflow;
    end
    else if (cpu_bit_op && key_hit)
    begin
      next_cause = wwt_pkg::wwt_cause_bit_op;
    end
    else if (key_bad)
    begin
      next_cause = wwt_pkg::wwt_cause_bad_key;
    end
    else if (key_closed)
    begin
      next_cause = wwt_pkg::wwt_cause_closed_write;
    end
    else if (fetch_bad)
    begin
      next_cause = wwt_pkg::wwt_cause_bad_fetch;
    end
    else if (access_bad)
    begin
      next_cause = wwt_pkg::wwt_cause_bad_access;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      count <= `WWT_CNT_W'(0);
    end
    else if (key_good)
    begin
      count <= `WWT_CNT_W'(0);
    end
    // A tick already in flight when a pause starts is dropped so the held count never moves.
    else if (tick_bus.tick && count_enable_opt && !clk_stopped)
    begin
      count <= count + `WWT_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      first_done <= 1'b0;
    end
    else if (key_good)
    begin
      first_done <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pending_err <= 1'b0;
    end
    else if (clk_stopped && err_now)
    begin
      pending_err <= 1'b1;
    end
    else if (fire)
    begin
      pending_err <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      wdt_reset_req <= 1'b0;
      reset_cause <= wwt_pkg::wwt_cause_none;
    end
    else
    begin
      wdt_reset_req <= fire;
      if (err_now || overflow)
      begin
        reset_cause <= next_cause;
      end
    end
  end

  // The flag survives until cleared; a new watchdog reset beats the clear.
  always_ff @(posedge sys_clk)
  begin
    if (srst && !wdt_reset_req)
    begin
      watchdog_reset_flag <= 1'b0;
    end
    else if (fire || wdt_reset_req)
    begin
      watchdog_reset_flag <= 1'b1;
    end
    else if (flag_clear)
    begin
      watchdog_reset_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      restart_key_reg <= opt_byte[`WWT_OPT_ENABLE] ? `WWT_KEY_RST_ON
        : `WWT_KEY_RST_OFF;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      cpu_rdata <= 8'h00;
    end
    else if (cpu_rd && cpu_addr == `WWT_KEY_ADDR)
    begin
      cpu_rdata <= restart_key_reg;
    end
    else
    begin
      cpu_rdata <= 8'h00;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  property p_key_clears;
    key_hit && !key_bad && !key_closed |=> count == `WWT_CNT_W'(0) && !wdt_reset_req;
  endproperty
  a_key_clears: assert property (p_key_clears)
    else $error("Valid key write did not clear the counter.");

  property p_reset_value;
    $fell(srst) |-> restart_key_reg == ($past(opt_byte[`WWT_OPT_ENABLE])
      ? `WWT_KEY_RST_ON : `WWT_KEY_RST_OFF);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("Key register reset value does not follow the enable option.");

  property p_bad_key;
    key_hit && cpu_wdata != `WWT_KEY_VALUE && !clk_stopped |=> wdt_reset_req;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("Wrong key value did not raise reset.");

  property p_bit_op;
    key_hit && cpu_bit_op |-> ##[1:1000] wdt_reset_req;
  endproperty
  a_bit_op: assert property (p_bit_op)
    else $error("Bit-level key write did not raise reset.");

  property p_readback;
    cpu_rd && cpu_addr == `WWT_KEY_ADDR |=> cpu_rdata != `WWT_KEY_VALUE
      && cpu_rdata == restart_key_reg;
  endproperty
  a_readback: assert property (p_readback)
    else $error("Key register read returned the wrong value.");

  property p_disabled_still;
    !count_enable_opt && !key_good |=> $stable(count) && !$past(fetch_bad);
  endproperty
  a_disabled_still: assert property (p_disabled_still)
    else $error("Disabled watchdog counted or checked accesses.");

  property p_closed_write;
    key_closed && !clk_stopped |=> wdt_reset_req
      && reset_cause == wwt_pkg::wwt_cause_closed_write;
  endproperty
  a_closed_write: assert property (p_closed_write)
    else $error("Write in closed window did not raise reset.");

  property p_first_write;
    !first_done && key_hit && !key_bad |-> !key_closed ##1 first_done;
  endproperty
  a_first_write: assert property (p_first_write)
    else $error("First key write was refused.");

  property p_overflow;
    tick_bus.tick && !clk_stopped && count_enable_opt && count == last_count && !key_hit
      |=> wdt_reset_req && reset_cause == wwt_pkg::wwt_cause_overflow;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("Overflow did not raise reset.");

  property p_bad_fetch;
    count_enable_opt && cpu_fetch && cpu_addr >= `WWT_SFR_BASE |=> wdt_reset_req;
  endproperty
  a_bad_fetch: assert property (p_bad_fetch)
    else $error("Fetch outside memory did not raise reset.");

  property p_exempt;
    cpu_rd && !cpu_fetch && cpu_addr >= `WWT_EXEMPT_BASE && !pending_err
      && !overflow |=> !wdt_reset_req;
  endproperty
  a_exempt: assert property (p_exempt)
    else $error("Read of exempt area raised reset.");

  property p_pause_hold;
    clk_stopped && !key_good |=> $stable(count);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("Counter moved while paused.");

  property p_flash_counts;
    flash_self_prog && tick_bus.tick && count_enable_opt && !clk_stopped && !key_good
      |=> count == $past(count) + `WWT_CNT_W'(1);
  endproperty
  a_flash_counts: assert property (p_flash_counts)
    else $error("Counter stalled during flash self-programming.");

  property p_flag;
    wdt_reset_req |-> watchdog_reset_flag;
  endproperty
  a_flag: assert property (p_flag)
    else $error("Watchdog reset without reset flag.");

endmodule : wwt_watchdog

// File: testbench/wwt_cpu_model.sv
// CPU core model that issues key writes, data accesses and instruction fetches.
`timescale 1ns/1ps
module wwt_cpu_model
(
  input wire logic sys_clk,
  output logic [15:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic cpu_fetch,
  output logic cpu_bit_op,
  output logic [7:0] cpu_wdata
);
  initial
  begin
    cpu_addr = 16'h0000;
    cpu_wdata = 8'h00;
    {cpu_wr, cpu_rd, cpu_fetch, cpu_bit_op} = 4'h0;
  end

  // One access of one cycle: op 0 byte write, 1 bit write, 2 data read, 3 fetch.
  // Released address and data lines show the inverse so stale values never match.
  task automatic access(input logic [1:0] op, input logic [15:0] addr, input logic [7:0] data);
    @(negedge sys_clk);
    cpu_addr = addr;
    cpu_wdata = data;
    cpu_wr = (op < 2'h2);
    cpu_bit_op = (op == 2'h1);
    cpu_rd = (op == 2'h2);
    cpu_fetch = (op == 2'h3);
    @(negedge sys_clk);
    {cpu_wr, cpu_rd, cpu_fetch, cpu_bit_op} = 4'h0;
    cpu_addr = ~addr;
    cpu_wdata = ~data;
  endtask : access
endmodule : wwt_cpu_model

// File: testbench/windowed_watchdog_timer_tb.sv
// Self-checking bench for the windowed watchdog core.
`timescale 1ns/1ps
`define WWT_CHECK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module windowed_watchdog_timer_tb;
  localparam int DIV = 2;
  typedef struct {
    logic [7:0] opt;
    logic [1:0] op;
    logic [15:0] addr;
    logic [7:0] data;
    logic req;
    wwt_pkg::wwt_cause_t cause;
  } wwt_row_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] opt_byte = 8'h70;
  logic halt_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic lowspeed_osc_stop = 1'b0;
  logic flash_self_prog = 1'b0;
  logic flag_clear = 1'b0;
  logic [7:0] memory_size_reg = 8'h03;
  logic [15:0] cpu_addr;
  logic cpu_wr, cpu_rd, cpu_fetch, cpu_bit_op;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic wdt_reset_req;
  logic watchdog_reset_flag;
  wwt_pkg::wwt_cause_t reset_cause;
  logic [7:0] req_seen = 8'h00;
  int miscompares = 0;
  int comparisons = 0;
  int n;
  wwt_row_t rows[13] = '{
    '{8'h70, 2'h0, 16'hff99, 8'hac, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h70, 2'h0, 16'hff99, 8'h55, 1'b1, wwt_pkg::wwt_cause_bad_key},
    '{8'h70, 2'h1, 16'hff99, 8'hac, 1'b1, wwt_pkg::wwt_cause_bit_op},
    '{8'h70, 2'h2, 16'hff99, 8'h00, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h60, 2'h2, 16'hff99, 8'h00, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h70, 2'h3, 16'h0100, 8'h00, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h70, 2'h3, 16'h1000, 8'h00, 1'b1, wwt_pkg::wwt_cause_bad_fetch},
    '{8'h70, 2'h2, 16'h2000, 8'h00, 1'b1, wwt_pkg::wwt_cause_bad_access},
    '{8'h70, 2'h0, 16'hfb00, 8'h12, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h70, 2'h3, 16'hff00, 8'h00, 1'b1, wwt_pkg::wwt_cause_bad_fetch},
    '{8'h70, 2'h3, 16'hfb00, 8'h00, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h60, 2'h3, 16'h1000, 8'h00, 1'b0, wwt_pkg::wwt_cause_none},
    '{8'h60, 2'h0, 16'hff99, 8'h55, 1'b1, wwt_pkg::wwt_cause_bad_key}
  };

  wwt_watchdog #(.SLOW_DIV(DIV)) u_wwt_watchdog (.sys_clk(sys_clk), .srst(srst),
    .opt_byte(opt_byte), .memory_size_reg(memory_size_reg), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_fetch(cpu_fetch), .cpu_bit_op(cpu_bit_op), .cpu_wdata(cpu_wdata),
    .halt_mode(halt_mode), .stop_mode(stop_mode), .lowspeed_osc_stop(lowspeed_osc_stop),
    .flash_self_prog(flash_self_prog), .flag_clear(flag_clear), .cpu_rdata(cpu_rdata),
    .wdt_reset_req(wdt_reset_req), .watchdog_reset_flag(watchdog_reset_flag),
    .reset_cause(reset_cause));

  wwt_cpu_model u_wwt_cpu_model (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_fetch(cpu_fetch), .cpu_bit_op(cpu_bit_op), .cpu_wdata(cpu_wdata));

  always #50 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
    if (wdt_reset_req === 1'b1)
      req_seen <= req_seen + 8'h01;

  task automatic summarize();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  task automatic restart(input logic [7:0] opt);
    @(negedge sys_clk);
    srst = 1'b1;
    opt_byte = opt;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    req_seen = 8'h00;
  endtask : restart

  task automatic idle(input int c);
    repeat (c) @(negedge sys_clk);
  endtask : idle

  task automatic key();
    u_wwt_cpu_model.access(2'h0, 16'hff99, 8'hac);
  endtask : key

  task automatic wait_req(input int lim);
    n = 0;
    while (req_seen === 8'h00 && n < lim)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= lim)
    begin
      miscompares++;
      summarize();
    end
  endtask : wait_req

  task automatic check_ovf(input int cyc);
    wait_req(cyc + 4 * DIV + 8);
    `WWT_CHECK((n > cyc - 2 * DIV - 4 && n < cyc + 2 * DIV + 4), 1'b1)
    `WWT_CHECK(reset_cause, wwt_pkg::wwt_cause_overflow)
  endtask : check_ovf

  initial
  begin
    repeat (6) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    `WWT_CHECK({cpu_rdata, wdt_reset_req, watchdog_reset_flag}, 10'h000)
    `WWT_CHECK(reset_cause, wwt_pkg::wwt_cause_none)
    foreach (rows[i])
    begin
      restart(rows[i].opt);
      u_wwt_cpu_model.access(rows[i].op, rows[i].addr, rows[i].data);
      if (rows[i].op == 2'h2)
      begin
        `WWT_CHECK(cpu_rdata, (rows[i].addr == 16'hff99) ? {rows[i].opt[4], 7'h1a} : 8'h00)
      end
      idle(3);
      `WWT_CHECK(req_seen, {7'h00, rows[i].req})
      `WWT_CHECK(watchdog_reset_flag, rows[i].req)
      `WWT_CHECK(reset_cause, rows[i].cause)
    end
    flag_clear = 1'b1;
    @(negedge sys_clk);
    flag_clear = 1'b0;
    `WWT_CHECK(watchdog_reset_flag, 1'b0)
    flag_clear = 1'b1;
    u_wwt_cpu_model.access(2'h0, 16'hff99, 8'h55);
    flag_clear = 1'b0;
    `WWT_CHECK(watchdog_reset_flag, 1'b1)
    memory_size_reg = 8'h0f;
    restart(8'h70);
    u_wwt_cpu_model.access(2'h3, 16'h3c00, 8'h00);
    idle(3);
    `WWT_CHECK(req_seen, 8'h00)
    restart(8'h70);
    key();
    // The second key lands on the very tick that would overflow.
    idle(1024 * DIV - 1);
    key();
    idle(3);
    `WWT_CHECK(req_seen, 8'h00)
    check_ovf(1024 * DIV);
    restart(8'h70);
    key();
    u_wwt_cpu_model.access(2'h2, 16'hff99, 8'h00);
    `WWT_CHECK(cpu_rdata, 8'h9a)
    for (int c = 0; c < 4; c++)
    begin
      restart({4'h7, c[2:0], 1'b0});
      flash_self_prog = c[0];
      key();
      check_ovf((1024 << c) * DIV);
    end
    flash_self_prog = 1'b0;
    restart(8'h71);
    key();
    halt_mode = 1'b1;
    check_ovf(1024 * DIV);
    halt_mode = 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      restart(8'h70);
      key();
      idle(500);
      {halt_mode, stop_mode, lowspeed_osc_stop} = 3'b100 >> s;
      idle(3000);
      `WWT_CHECK(req_seen, 8'h00)
      {halt_mode, stop_mode, lowspeed_osc_stop} = 3'b000;
      check_ovf(1024 * DIV - 500);
    end
    for (int b = 0; b < 2; b++)
    begin
      restart(8'h70);
      key();
      {stop_mode, lowspeed_osc_stop} = 2'b10 >> b;
      u_wwt_cpu_model.access(b[1:0], 16'hff99, (b == 1) ? 8'hac : 8'h55);
      idle(20);
      `WWT_CHECK(req_seen, 8'h00)
      {stop_mode, lowspeed_osc_stop} = 2'b00;
      wait_req(10);
      `WWT_CHECK(reset_cause, (b == 1) ? wwt_pkg::wwt_cause_bit_op : wwt_pkg::wwt_cause_bad_key)
    end
    for (int w = 0; w < 4; w++)
    begin
      restart({1'b0, w[1:0], 5'h12});
      key();
      if (w < 3)
      begin
        idle((512 * (3 - w) - 8) * DIV);
        key();
        idle(3);
        `WWT_CHECK(reset_cause, wwt_pkg::wwt_cause_closed_write)
        restart({1'b0, w[1:0], 5'h12});
        key();
      end
      idle((512 * (3 - w) + 8) * DIV);
      key();
      idle(3);
      `WWT_CHECK(req_seen, 8'h00)
    end
    summarize();
  end
endmodule : windowed_watchdog_timer_tb
